// >>> design/uie_top.sv
// Purpose: ahb-lite register block for two uart channels' interrupt logic
// Assumes: all uart source flags are synchronous to hclk
// Notes: writes take no wait state, reads take one
//
// Function
// RULE1 - modem enable bit 3 requests interrupt while any flag [3:1] set
// RULE2 - line status enable bit 2 requests interrupt while any error flag set
// RULE3 - tx empty enable bit 1 requests interrupt when tx buffer goes empty
// RULE4 - without fifo, rx enable bit 0 requests on received character
// RULE5 - with fifo, rx enable bit 0 gates the trigger level request
// RULE6 - rx enable bit 0 also gates the receive timeout request
// RULE7 - each channel has a read/write divisor high byte, reset 0x00
// RULE8 - each channel has a read-only identification register, reset 0x01
// RULE9 - identification bits [7:6] read 0x0 without fifo, 0x3 with fifo
// RULE10 - identification bit 0 is one when nothing enabled is pending
// RULE11 - causes: line 011 first, rx 010, timeout 110, tx 001, modem 000
// RULE12 - interrupt enable bits [7:4] read zero and ignore writes
//
// Decided for this implementation: the AHB-Lite register port.
module uie_top
    import uie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,

    input wire logic [3:1] modem_status_flags0,
    input wire logic [3:1] modem_status_flags1,
    input wire logic [3:0] line_status_flags0,
    input wire logic [3:0] line_status_flags1,
    input wire logic [1:0] tx_empty,
    input wire logic [1:0] tx_write,
    input wire logic [1:0] rx_data_ready,
    input wire logic [1:0] rx_trigger,
    input wire logic [1:0] rx_timeout,

    output logic [1:0] fifo_enable,
    output logic [7:0] divisor_high0,
    output logic [7:0] divisor_high1,
    output logic [1:0] uart_irq_request,
    output logic irq
);

    logic accept;
    logic wr_pend_q;
    logic rd_pend_q;
    uie_reg_type reg_q;
    logic [31:0] hrdata_q;

    logic [7:0] div0_q;
    logic [7:0] div1_q;
    logic [3:0] en0_q;
    logic [3:0] en1_q;
    logic [1:0] ctrl_q;

    logic [7:0] ident0;
    logic [7:0] ident1;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [31:0] rd_mux;
    logic wr_en;

    ////////////////////////////////////////////////////////////////////////
    // only hsize word transfers are expected, so hsize is not decoded
    assign accept = hsel & hready & htrans[1];
    assign wr_en = wr_pend_q;

    // latch the address phase; data acts next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            reg_q <= UIE_REG_NONE;
        end else begin
            if (hready) begin
                wr_pend_q <= accept & hwrite;
            end else begin
                wr_pend_q <= 1'b0;
            end
            rd_pend_q <= accept & ~hwrite;
            if (accept) begin
                reg_q <= uie_decode(haddr);
            end
        end
    end

    // the wait state lets a read see a write made just before it
    assign hreadyout = ~rd_pend_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    ////////////////////////////////////////////////////////////////////////
    // plain storage for the baud divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div0_q <= UIE_DIV_HIGH_RESET;
            div1_q <= UIE_DIV_HIGH_RESET;
        end else if (wr_en) begin
            if (reg_q == UIE_REG_U0_DIV) begin
                div0_q <= hwdata[7:0]; // see RULE7
            end
            if (reg_q == UIE_REG_U1_DIV) begin
                div1_q <= hwdata[7:0]; // see RULE7
            end
        end
    end

    // upper enable bits have no storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en0_q <= UIE_IRQ_EN_RESET;
            en1_q <= UIE_IRQ_EN_RESET;
        end else if (wr_en) begin
            if (reg_q == UIE_REG_U0_EN) begin
                en0_q <= hwdata[UIE_EN_WIDTH-1:0]; // see RULE12
            end
            if (reg_q == UIE_REG_U1_EN) begin
                en1_q <= hwdata[UIE_EN_WIDTH-1:0]; // see RULE12
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= UIE_CTRL_RESET;
        end else if (wr_en && reg_q == UIE_REG_CTRL) begin
            ctrl_q <= hwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_q)
            UIE_REG_U0_DIV: rd_mux = {24'h00_0000, div0_q};
            UIE_REG_U0_IDENT: rd_mux = {24'h00_0000, ident0}; // see RULE8
            UIE_REG_U0_EN: rd_mux = {28'h000_0000, en0_q}; // see RULE12
            UIE_REG_U1_DIV: rd_mux = {24'h00_0000, div1_q};
            UIE_REG_U1_IDENT: rd_mux = {24'h00_0000, ident1}; // see RULE8
            UIE_REG_U1_EN: rd_mux = {28'h000_0000, en1_q}; // see RULE12
            UIE_REG_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
            UIE_REG_EVT_STATUS: rd_mux = {30'h0000_0000, evt_status};
            UIE_REG_EVT_MASK: rd_mux = {30'h0000_0000, evt_mask};
            UIE_REG_NONE: rd_mux = 32'h0000_0000;
        endcase
    end

    // holds until the next read's wait cycle ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // each channel gets its own enable and fifo bit
    uie_channel u_ch0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .irq_enable(en0_q),
        .fifo_enable(ctrl_q[0]),
        .modem_status_flags(modem_status_flags0),
        .line_status_flags(line_status_flags0),
        .tx_empty(tx_empty[0]),
        .tx_write(tx_write[0]),
        .rx_data_ready(rx_data_ready[0]),
        .rx_trigger(rx_trigger[0]),
        .rx_timeout(rx_timeout[0]),
        .ident_read(rd_pend_q && reg_q == UIE_REG_U0_IDENT),
        .ident(ident0),
        .irq_request(uart_irq_request[0])
    );

    uie_channel u_ch1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .irq_enable(en1_q),
        .fifo_enable(ctrl_q[1]),
        .modem_status_flags(modem_status_flags1),
        .line_status_flags(line_status_flags1),
        .tx_empty(tx_empty[1]),
        .tx_write(tx_write[1]),
        .rx_data_ready(rx_data_ready[1]),
        .rx_trigger(rx_trigger[1]),
        .rx_timeout(rx_timeout[1]),
        .ident_read(rd_pend_q && reg_q == UIE_REG_U1_IDENT),
        .ident(ident1),
        .irq_request(uart_irq_request[1])
    );

    // a held request level sets status only once
    uie_irq u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .request(uart_irq_request),
        .wr_status(wr_en && reg_q == UIE_REG_EVT_STATUS),
        .wr_mask(wr_en && reg_q == UIE_REG_EVT_MASK),
        .wdata(hwdata[1:0]),
        .status(evt_status),
        .mask(evt_mask),
        .irq(irq)
    );

    assign fifo_enable = ctrl_q;
    assign divisor_high0 = div0_q;
    assign divisor_high1 = div1_q;

    ////////////////////////////////////////////////////////////////////////
    property p_div_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && reg_q == UIE_REG_U1_DIV
        |=> divisor_high1 == $past(hwdata[7:0]);
    endproperty
    a_div_write: assert property (p_div_write) // see RULE7
        else $error("divisor high byte not stored");

    property p_ident_read;
        @(posedge hclk) disable iff (!hresetn)
        rd_pend_q && reg_q == UIE_REG_U0_IDENT
        |=> hreadyout && hrdata == {24'h00_0000, $past(ident0)};
    endproperty
    a_ident_read: assert property (p_ident_read) // see RULE8
        else $error("identification read returned wrong value");

    property p_en_upper;
        @(posedge hclk) disable iff (!hresetn)
        rd_pend_q && (reg_q == UIE_REG_U0_EN || reg_q == UIE_REG_U1_EN)
        |=> hrdata[31:4] == 28'h000_0000;
    endproperty
    a_en_upper: assert property (p_en_upper) // see RULE12
        else $error("enable upper bits not zero");

    c_read: cover property (@(posedge hclk) disable iff (!hresetn)
        accept && !hwrite ##1 !hreadyout ##1 hreadyout);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));

    // bus timing, storage, request and irq consistency checks
    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");

    property p_write_fast;
        @(posedge hclk) disable iff (!hresetn)
        accept && hwrite |=> hreadyout;
    endproperty
    a_write_fast: assert property (p_write_fast)
        else $error("write was stalled");

    property p_div0_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && reg_q == UIE_REG_U0_DIV |=> div0_q == $past(hwdata[7:0]);
    endproperty
    a_div0_write: assert property (p_div0_write) // see RULE7
        else $error("divisor0 not stored");

    property p_en_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && reg_q == UIE_REG_U1_EN |=> en1_q == $past(hwdata[3:0]);
    endproperty
    a_en_write: assert property (p_en_write) // see RULE12
        else $error("enable bits not stored");

    property p_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && reg_q == UIE_REG_CTRL |=> ctrl_q == $past(hwdata[1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // see RULE9
        else $error("fifo enable not stored");

    property p_req_ident;
        @(posedge hclk) disable iff (!hresetn)
        uart_irq_request == ~{ident1[0], ident0[0]};
    endproperty
    a_req_ident: assert property (p_req_ident) // see RULE10
        else $error("request disagrees with ident");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        irq == |(evt_status & evt_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq disagrees with status");

    c_write: cover property (@(posedge hclk) disable iff (!hresetn)
        accept && hwrite ##1 wr_en);

endmodule

// >>> design/uie_pkg.sv
// Purpose: shared constants for the uart interrupt enable/identify block
// Assumes: 32-bit ahb-lite data, one aligned word per register
// Notes: all byte addresses are full 32-bit values
package uie_pkg;

    localparam logic [31:0] UIE_U0_DIV_HIGH_ADDR = 32'hffff0704;
    localparam logic [31:0] UIE_U0_IDENT_ADDR = 32'hffff0708;
    localparam logic [31:0] UIE_U0_IRQ_EN_ADDR = 32'hffff0710;
    localparam logic [31:0] UIE_U1_DIV_HIGH_ADDR = 32'hffff0744;
    localparam logic [31:0] UIE_U1_IDENT_ADDR = 32'hffff0748;
    localparam logic [31:0] UIE_U1_IRQ_EN_ADDR = 32'hffff0750;
    localparam logic [31:0] UIE_CTRL_ADDR = 32'hffff0780;
    localparam logic [31:0] UIE_EVT_STATUS_ADDR = 32'hffff0784;
    localparam logic [31:0] UIE_EVT_MASK_ADDR = 32'hffff0788;

    // interrupt enable field positions
    localparam int UIE_EN_MODEM_BIT = 3;
    localparam int UIE_EN_LINE_BIT = 2;
    localparam int UIE_EN_TX_BIT = 1;
    localparam int UIE_EN_RX_BIT = 0;
    localparam int UIE_EN_WIDTH = 4;

    // reset values
    localparam logic [7:0] UIE_IDENT_RESET = 8'h01;
    localparam logic [7:0] UIE_DIV_HIGH_RESET = 8'h00;
    localparam logic [3:0] UIE_IRQ_EN_RESET = 4'h0;
    localparam logic [1:0] UIE_CTRL_RESET = 2'h0;
    localparam logic [1:0] UIE_EVT_RESET = 2'h0;

    // identification fields
    localparam logic [1:0] UIE_MODE_NON_FIFO = 2'h0;
    localparam logic [1:0] UIE_MODE_FIFO = 2'h3;
    localparam logic [2:0] UIE_CAUSE_LINE = 3'h3;
    localparam logic [2:0] UIE_CAUSE_RX = 3'h2;
    localparam logic [2:0] UIE_CAUSE_TIMEOUT = 3'h6;
    localparam logic [2:0] UIE_CAUSE_TX = 3'h1;
    localparam logic [2:0] UIE_CAUSE_MODEM = 3'h0;

    typedef enum logic [3:0] {
        UIE_REG_NONE,
        UIE_REG_U0_DIV,
        UIE_REG_U0_IDENT,
        UIE_REG_U0_EN,
        UIE_REG_U1_DIV,
        UIE_REG_U1_IDENT,
        UIE_REG_U1_EN,
        UIE_REG_CTRL,
        UIE_REG_EVT_STATUS,
        UIE_REG_EVT_MASK
    } uie_reg_type;

    function automatic uie_reg_type uie_decode(input logic [31:0] addr);
        uie_reg_type r;
        r = UIE_REG_NONE;
        unique case (addr)
            UIE_U0_DIV_HIGH_ADDR: r = UIE_REG_U0_DIV;
            UIE_U0_IDENT_ADDR: r = UIE_REG_U0_IDENT;
            UIE_U0_IRQ_EN_ADDR: r = UIE_REG_U0_EN;
            UIE_U1_DIV_HIGH_ADDR: r = UIE_REG_U1_DIV;
            UIE_U1_IDENT_ADDR: r = UIE_REG_U1_IDENT;
            UIE_U1_IRQ_EN_ADDR: r = UIE_REG_U1_EN;
            UIE_CTRL_ADDR: r = UIE_REG_CTRL;
            UIE_EVT_STATUS_ADDR: r = UIE_REG_EVT_STATUS;
            UIE_EVT_MASK_ADDR: r = UIE_REG_EVT_MASK;
            default: r = UIE_REG_NONE;
        endcase
        return r;
    endfunction

endpackage

// >>> design/uie_channel.sv
// Purpose: interrupt cause selection and identification for one channel
// Assumes: source flags come from logic on hclk
// Notes: identification value is combinational, read through hrdata flop
module uie_channel
    import uie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] irq_enable,
    input wire logic fifo_enable,
    input wire logic [3:1] modem_status_flags,
    input wire logic [3:0] line_status_flags,
    input wire logic tx_empty,
    input wire logic tx_write,
    input wire logic rx_data_ready,
    input wire logic rx_trigger,
    input wire logic rx_timeout,
    input wire logic ident_read,
    output logic [7:0] ident,
    output logic irq_request
);

    logic tx_empty_prev_q;
    logic tx_pend_q;
    logic tx_rise;
    logic line_req;
    logic rx_req;
    logic to_req;
    logic tx_req;
    logic ms_req;
    logic no_irq_pending;
    logic [2:0] cause;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // empty buffer is the idle level, so no edge at reset
            tx_empty_prev_q <= 1'b1;
        end else begin
            tx_empty_prev_q <= tx_empty;
        end
    end

    assign tx_rise = tx_empty & ~tx_empty_prev_q;

    // set wins, so an empty edge during the clearing read is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_pend_q <= 1'b0;
        end else if (tx_rise) begin
            tx_pend_q <= 1'b1; // see RULE3
        end else if (tx_write || (ident_read && !no_irq_pending
                                  && cause == UIE_CAUSE_TX)) begin
            tx_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ms_req = irq_enable[UIE_EN_MODEM_BIT]
                    & (|modem_status_flags); // see RULE1
    assign line_req = irq_enable[UIE_EN_LINE_BIT]
                      & (|line_status_flags); // see RULE2
    assign tx_req = irq_enable[UIE_EN_TX_BIT] & tx_pend_q; // see RULE3
    // see RULE4 see RULE5
    assign rx_req = irq_enable[UIE_EN_RX_BIT]
                    & (fifo_enable ? rx_trigger : rx_data_ready);
    // timeout only exists with the fifo on
    assign to_req = irq_enable[UIE_EN_RX_BIT] & fifo_enable
                    & rx_timeout; // see RULE6

    always_comb begin
        no_irq_pending = 1'b0;
        cause = UIE_CAUSE_MODEM;
        if (line_req) begin
            cause = UIE_CAUSE_LINE; // see RULE11
        end else if (rx_req) begin
            cause = UIE_CAUSE_RX;
        end else if (to_req) begin
            cause = UIE_CAUSE_TIMEOUT;
        end else if (tx_req) begin
            cause = UIE_CAUSE_TX;
        end else if (ms_req) begin
            cause = UIE_CAUSE_MODEM;
        end else begin
            no_irq_pending = 1'b1; // see RULE10
        end
    end

    // see RULE8 see RULE9
    assign ident = {fifo_enable ? UIE_MODE_FIFO : UIE_MODE_NON_FIFO,
                    2'b00, cause, no_irq_pending};
    assign irq_request = ~no_irq_pending;

    ////////////////////////////////////////////////////////////////////////
    property p_modem;
        @(posedge hclk) disable iff (!hresetn)
        irq_enable[3] && (|modem_status_flags) |-> !no_irq_pending;
    endproperty
    a_modem: assert property (p_modem) // see RULE1
        else $error("modem status did not raise a request");

    property p_line;
        @(posedge hclk) disable iff (!hresetn)
        irq_enable[2] && (|line_status_flags)
        |-> ident[3:1] == 3'h3 && !ident[0];
    endproperty
    a_line: assert property (p_line) // see RULE2
        else $error("line status not reported first");

    property p_tx;
        @(posedge hclk) disable iff (!hresetn)
        irq_enable[1] && $rose(tx_empty) ##1 irq_enable[1]
        |-> irq_request;
    endproperty
    a_tx: assert property (p_tx) // see RULE3
        else $error("tx empty edge gave no request");

    property p_rx_plain;
        @(posedge hclk) disable iff (!hresetn)
        !fifo_enable && irq_enable[0] && rx_data_ready && !line_req
        |-> ident[3:0] == 4'h4;
    endproperty
    a_rx_plain: assert property (p_rx_plain) // see RULE4
        else $error("receive data cause missing");

    property p_rx_fifo;
        @(posedge hclk) disable iff (!hresetn)
        fifo_enable && irq_enable[0] && rx_trigger && !line_req
        |-> ident[3:0] == 4'h4;
    endproperty
    a_rx_fifo: assert property (p_rx_fifo) // see RULE5
        else $error("trigger level cause missing");

    property p_rx_gate;
        @(posedge hclk) disable iff (!hresetn)
        !irq_enable[0] |-> ident[0] || (ident[3:1] != 3'h2
                                        && ident[3:1] != 3'h6);
    endproperty
    a_rx_gate: assert property (p_rx_gate) // see RULE6
        else $error("receive cause shown while disabled");

    property p_mode;
        @(posedge hclk) disable iff (!hresetn)
        ident[7:6] == (fifo_enable ? 2'h3 : 2'h0) && ident[5:4] == 2'h0;
    endproperty
    a_mode: assert property (p_mode) // see RULE9
        else $error("fifo mode flag wrong");

    property p_none;
        @(posedge hclk) disable iff (!hresetn)
        ident[0] == !(line_req || rx_req || to_req || tx_req || ms_req);
    endproperty
    a_none: assert property (p_none) // see RULE10
        else $error("no-pending bit disagrees with sources");

    property p_order;
        @(posedge hclk) disable iff (!hresetn)
        to_req && tx_req && !line_req && !rx_req
        |-> ident[3:0] == 4'hc;
    endproperty
    a_order: assert property (p_order) // see RULE11
        else $error("timeout did not beat tx empty");

    c_timeout: cover property (@(posedge hclk) disable iff (!hresetn)
        ident[3:0] == 4'hc);
    c_tx_cleared: cover property (@(posedge hclk) disable iff (!hresetn)
        tx_pend_q ##1 !tx_pend_q);

endmodule

// >>> design/uie_irq.sv
// Purpose: sticky event status, mask and the single interrupt line
// Assumes: events are request rises of each channel
// Notes: write one to clear; a new event in the same cycle wins
module uie_irq
    import uie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] request,
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [1:0] wdata,
    output logic [1:0] status,
    output logic [1:0] mask,
    output logic irq
);

    logic [1:0] req_prev_q;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic irq_q;

    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~wdata;
        end
        status_d = status_d | (request & ~req_prev_q);
        mask_d = wr_mask ? wdata : mask_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_prev_q <= UIE_EVT_RESET;
            status_q <= UIE_EVT_RESET;
            mask_q <= UIE_EVT_RESET;
            irq_q <= 1'b0;
        end else begin
            req_prev_q <= request;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= |(status_d & mask_d);
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

endmodule

// >>> verification/uie_tb.sv
// Purpose: self-checking bench for the uart interrupt enable/identify block
// Assumes: one ahb-lite master, all uart source flags driven on hclk
// Notes: assertions live in the design files, this bench drives every port
module tb
    import uie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:1] modem_status_flags0, modem_status_flags1;
    logic [3:0] line_status_flags0, line_status_flags1;
    logic [1:0] tx_empty, tx_write, rx_data_ready, rx_trigger, rx_timeout;
    logic [1:0] fifo_enable, uart_irq_request;
    logic [7:0] divisor_high0, divisor_high1;
    int bad_count = 0;
    int checked = 0;

    assign hready = hreadyout;

    uie_top uie_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp),
        .modem_status_flags0(modem_status_flags0),
        .modem_status_flags1(modem_status_flags1),
        .line_status_flags0(line_status_flags0),
        .line_status_flags1(line_status_flags1), .tx_empty(tx_empty),
        .tx_write(tx_write), .rx_data_ready(rx_data_ready),
        .rx_trigger(rx_trigger), .rx_timeout(rx_timeout),
        .fifo_enable(fifo_enable), .divisor_high0(divisor_high0),
        .divisor_high1(divisor_high1), .uart_irq_request(uart_irq_request),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounded: a slave that never answers must not hang the run
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // sampled at the falling edge so the value equals what the rising edge sees
    task automatic wait_ready();
        int n;
        logic r;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd_q = hrdata;
            @(posedge hclk);
            n++;
            if (n > 20) begin
                bad_count++;
                $display("Error at %0t: no hready", $time);
                end_sim();
            end
        end while (r !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= d;
        wait_ready();
        chk({31'h0, hresp}, 32'h0, "response");
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_q, exp, "read data");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        modem_status_flags0 = 3'h0;
        modem_status_flags1 = 3'h0;
        line_status_flags0 = 4'h0;
        line_status_flags1 = 4'h0;
        tx_empty = 2'h0;
        tx_write = 2'h0;
        rx_data_ready = 2'h0;
        rx_trigger = 2'h0;
        rx_timeout = 2'h0;
        cyc(10);
        hresetn <= 1'b1;
        // reset values and read-only places
        rc(UIE_U0_DIV_HIGH_ADDR, 32'h00);
        rc(UIE_U1_DIV_HIGH_ADDR, 32'h00);
        rc(UIE_U0_IDENT_ADDR, 32'h01);
        rc(UIE_U1_IDENT_ADDR, 32'h01);
        wr(UIE_U0_IDENT_ADDR, 32'hff);
        rc(UIE_U0_IDENT_ADDR, 32'h01);
        rc(32'hffff0790, 32'h0);
        // divisor writes with one idle cycle between, distinct per channel
        wr(UIE_U0_DIV_HIGH_ADDR, 32'h5a);
        wr(UIE_U1_DIV_HIGH_ADDR, 32'ha5);
        rc(UIE_U0_DIV_HIGH_ADDR, 32'h5a);
        rc(UIE_U1_DIV_HIGH_ADDR, 32'ha5);
        chk({24'h0, divisor_high0}, 32'h5a, "divisor0 out");
        chk({24'h0, divisor_high1}, 32'ha5, "divisor1 out");
        wr(UIE_U0_IRQ_EN_ADDR, 32'hff);
        rc(UIE_U0_IRQ_EN_ADDR, 32'h0f);
        // priority walk in fifo mode on channel 0
        wr(UIE_CTRL_ADDR, 32'h1);
        rc(UIE_U0_IDENT_ADDR, 32'hc1);
        chk({30'h0, fifo_enable}, 32'h1, "fifo enable out");
        @(posedge hclk);
        line_status_flags0 <= 4'h8;
        rx_trigger <= 2'h1;
        rx_timeout <= 2'h1;
        modem_status_flags0 <= 3'h2;
        rc(UIE_U0_IDENT_ADDR, 32'hc6);
        line_status_flags0 <= 4'h0;
        rc(UIE_U0_IDENT_ADDR, 32'hc4);
        rx_trigger <= 2'h0;
        tx_empty <= 2'h1;
        rc(UIE_U0_IDENT_ADDR, 32'hcc);
        wr(UIE_U0_IRQ_EN_ADDR, 32'h0e);
        rc(UIE_U0_IDENT_ADDR, 32'hc2);
        rc(UIE_U0_IDENT_ADDR, 32'hc0);
        rx_timeout <= 2'h0;
        tx_empty <= 2'h0;
        cyc(1);
        tx_empty <= 2'h1;
        wr(UIE_U0_IRQ_EN_ADDR, 32'h02);
        cyc(1);
        chk({31'h0, uart_irq_request[0]}, 32'h1, "tx pend");
        tx_write <= 2'h1;
        cyc(1);
        tx_write <= 2'h0;
        rc(UIE_U0_IDENT_ADDR, 32'hc1);
        chk({31'h0, uart_irq_request[0]}, 32'h0, "tx clear");
        wr(UIE_U0_IRQ_EN_ADDR, 32'h07);
        rc(UIE_U0_IDENT_ADDR, 32'hc1);
        // non-fifo: timeout and trigger ignored, data ready counts
        wr(UIE_CTRL_ADDR, 32'h0);
        wr(UIE_U0_IRQ_EN_ADDR, 32'h01);
        rx_timeout <= 2'h1;
        rx_trigger <= 2'h1;
        rc(UIE_U0_IDENT_ADDR, 32'h01);
        rx_data_ready <= 2'h1;
        rc(UIE_U0_IDENT_ADDR, 32'h04);
        rx_data_ready <= 2'h0;
        rx_timeout <= 2'h0;
        rx_trigger <= 2'h0;
        modem_status_flags0 <= 3'h0;
        // channel 1 sources
        wr(UIE_U1_IRQ_EN_ADDR, 32'h0c);
        modem_status_flags1 <= 3'h4;
        rc(UIE_U1_IDENT_ADDR, 32'h00);
        line_status_flags1 <= 4'h1;
        rc(UIE_U1_IDENT_ADDR, 32'h06);
        chk({30'h0, uart_irq_request}, 32'h2, "request lines");
        line_status_flags1 <= 4'h0;
        modem_status_flags1 <= 3'h0;
        // sticky status, mask and the interrupt line
        wr(UIE_EVT_STATUS_ADDR, 32'h3);
        rc(UIE_EVT_STATUS_ADDR, 32'h0);
        wr(UIE_U0_IRQ_EN_ADDR, 32'h04);
        line_status_flags0 <= 4'h2;
        cyc(2);
        line_status_flags0 <= 4'h0;
        rc(UIE_EVT_STATUS_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(UIE_EVT_MASK_ADDR, 32'h1);
        rc(UIE_EVT_MASK_ADDR, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(UIE_EVT_STATUS_ADDR, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rc(UIE_EVT_STATUS_ADDR, 32'h0);
        end_sim();
    end
endmodule
